// [shared/gpx_regs.vh]
`ifndef GPX_REGS_VH
`define GPX_REGS_VH

// ------------------------------------------------------------
// register offsets (command byte bits 6:1)
// ------------------------------------------------------------
`define GPX_OFF_PIN_STATE 6'h00
`define GPX_OFF_OUTPUT_VALUE 6'h01
`define GPX_OFF_POLARITY 6'h02
`define GPX_OFF_DIRECTION 6'h03
`define GPX_OFF_PULLUP 6'h04
`define GPX_OFF_IRQ_ENABLE 6'h05
`define GPX_OFF_HIGHZ 6'h06
`define GPX_OFF_IRQ_STATUS 6'h07
`define GPX_OFF_RISE_EN 6'h08
`define GPX_OFF_FALL_EN 6'h09
`define GPX_OFF_FILTER_EN 6'h0a

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define GPX_RST_OUTPUT_VALUE 8'hff
`define GPX_RST_POLARITY 8'h00
`define GPX_RST_DIRECTION 8'hff
`define GPX_RST_PULLUP 8'h00
`define GPX_RST_IRQ_ENABLE 8'h00
`define GPX_RST_HIGHZ 8'h00
`define GPX_RST_RISE_EN 8'h00
`define GPX_RST_FALL_EN 8'h00
`define GPX_RST_FILTER_EN 8'hff

// ------------------------------------------------------------
// command byte fields and frame length
// ------------------------------------------------------------
`define GPX_CMD_READ_BIT 7
`define GPX_CMD_ADDR_MSB 6
`define GPX_CMD_ADDR_LSB 1
`define GPX_FRAME_BITS 5'h10

// ------------------------------------------------------------
// filter timing
// ------------------------------------------------------------
`define GPX_CLK_PERIOD_NS 10
`define GPX_FILT_REJECT_NS 225
`define GPX_FILT_ACCEPT_NS 1075
// a pulse just under the reject limit can still cover one sample
// more than the limit divided by the period, so require one beyond
`define GPX_FILT_CYC \
    ((`GPX_FILT_REJECT_NS - 1) / `GPX_CLK_PERIOD_NS + 2)

`endif

// [src/gpx_pin_filter.v]
`timescale 1ns/100ps
`include "gpx_regs.vh"

module gpx_pin_filter (
    input wire clock,
    input wire rst,
    input wire pin_async,
    input wire filt_en,
    output reg live_level,
    output reg filt_level
);

    localparam integer FILT_CYC = `GPX_FILT_CYC;
    localparam [4:0] FILT_LAST = FILT_CYC[4:0] - 5'h01;

    reg sync1;
    reg sync2;
    reg sync3;
    reg [4:0] cnt;

    // ------------------------------------------------------------
    // three-stage synchroniser, change taken when stages 2 and 3 agree
    // ------------------------------------------------------------
    always @(posedge clock) begin
        if (rst) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
            live_level <= 1'b0;
        end else begin
            sync1 <= pin_async;
            sync2 <= sync1;
            sync3 <= sync2;
            if (sync2 == sync3) begin
                live_level <= sync3;
            end
        end
    end

    // ------------------------------------------------------------
    // pulse-width filter
    // ------------------------------------------------------------
    // threshold sits one sample past the reject limit so every pulse
    // past the accept limit still passes with wide margin
    always @(posedge clock) begin
        if (rst) begin
            cnt <= 5'h00;
            filt_level <= 1'b0;
        end else if (!filt_en) begin
            cnt <= 5'h00;
            filt_level <= live_level;
        end else if (live_level == filt_level) begin
            cnt <= 5'h00;
        end else if (cnt == FILT_LAST) begin
            cnt <= 5'h00;
            filt_level <= live_level;
        end else begin
            cnt <= cnt + 5'h01;
        end
    end

endmodule

// [src/gpx_spi_slave.v]
`timescale 1ns/100ps
`include "gpx_regs.vh"

module gpx_spi_slave (
    input wire clock,
    input wire rst,
    input wire spi_scl,
    input wire spi_cs_n,
    input wire spi_si,
    input wire [7:0] rd_word,
    output reg spi_so,
    output reg spi_so_oe,
    output reg rd_pulse,
    output reg wr_pulse,
    output reg [5:0] reg_addr,
    output reg [7:0] wr_data
);

    reg [2:0] scl_s;
    reg [2:0] cs_s;
    reg [2:0] si_s;
    reg scl_q;
    reg cs_n_q;
    reg si_q;
    reg [4:0] bit_cnt;
    reg [6:0] shift_in;
    reg [7:0] shift_out;
    reg is_read;

    wire scl_rise = (scl_s[2] == scl_s[1]) && scl_s[2] && !scl_q;
    wire scl_fall = (scl_s[2] == scl_s[1]) && !scl_s[2] && scl_q;
    wire [7:0] byte_in = {shift_in, si_q};

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always @(posedge clock) begin
        if (rst) begin
            scl_s <= 3'h0;
            cs_s <= 3'h7;
            si_s <= 3'h0;
            scl_q <= 1'b0;
            cs_n_q <= 1'b1;
            si_q <= 1'b0;
        end else begin
            scl_s <= {scl_s[1:0], spi_scl};
            cs_s <= {cs_s[1:0], spi_cs_n};
            si_s <= {si_s[1:0], spi_si};
            if (scl_s[2] == scl_s[1]) begin
                scl_q <= scl_s[2];
            end
            if (cs_s[2] == cs_s[1]) begin
                cs_n_q <= cs_s[2];
            end
            if (si_s[2] == si_s[1]) begin
                si_q <= si_s[2];
            end
        end
    end

    // ------------------------------------------------------------
    // frame: command byte then one data byte, msb first
    // ------------------------------------------------------------
    always @(posedge clock) begin
        rd_pulse <= 1'b0;
        wr_pulse <= 1'b0;
        if (rst) begin
            bit_cnt <= 5'h00;
            shift_in <= 7'h00;
            shift_out <= 8'h00;
            is_read <= 1'b0;
            reg_addr <= 6'h00;
            wr_data <= 8'h00;
            spi_so <= 1'b0;
            spi_so_oe <= 1'b0;
        end else if (cs_n_q) begin
            bit_cnt <= 5'h00;
            spi_so_oe <= 1'b0;
        end else begin
            spi_so_oe <= 1'b1;
            if (scl_rise && bit_cnt != `GPX_FRAME_BITS) begin
                shift_in <= byte_in[6:0];
                bit_cnt <= bit_cnt + 5'h01;
                if (bit_cnt == 5'h07) begin
                    is_read <= byte_in[`GPX_CMD_READ_BIT];
                    reg_addr <= byte_in[`GPX_CMD_ADDR_MSB:`GPX_CMD_ADDR_LSB];
                    rd_pulse <= byte_in[`GPX_CMD_READ_BIT];
                end
                if (bit_cnt == 5'h0f && !is_read) begin
                    wr_data <= byte_in;
                    wr_pulse <= 1'b1;
                end
            end
            // rd_word settles one cycle after rd_pulse, long before
            // the next falling edge can be seen through the sync
            if (scl_fall && is_read) begin
                if (bit_cnt == 5'h08) begin
                    spi_so <= rd_word[7];
                    shift_out <= {rd_word[6:0], 1'b0};
                end else begin
                    spi_so <= shift_out[7];
                    shift_out <= {shift_out[6:0], 1'b0};
                end
            end
        end
    end

endmodule

// [src/gpx_port.v]
`timescale 1ns/100ps
`include "gpx_regs.vh"

module gpx_port (
    input wire clock,
    input wire rst,
    input wire spi_scl,
    input wire spi_cs_n,
    input wire spi_si,
    output wire spi_so,
    output wire spi_so_oe,
    input wire [7:0] gpio_pins_in,
    output reg [7:0] gpio_pins_out,
    output reg [7:0] gpio_pins_oe,
    output reg [7:0] gpio_pullup_en,
    output reg irq_n
);

    // ------------------------------------------------------------
    // register set
    // ------------------------------------------------------------
    reg [7:0] output_value;
    reg [7:0] input_polarity_invert;
    reg [7:0] pin_direction;
    reg [7:0] pullup_enable;
    reg [7:0] input_irq_enable;
    reg [7:0] output_highz_control;
    reg [7:0] irq_pending_status;
    reg [7:0] rising_edge_enable;
    reg [7:0] falling_edge_enable;
    reg [7:0] input_glitch_filter_enable;

    // ------------------------------------------------------------
    // internal state
    // ------------------------------------------------------------
    reg [7:0] rd_word;
    reg [7:0] rd_next;
    reg [7:0] prev_level;
    reg [7:0] snap_level;
    wire [7:0] live_level;
    wire [7:0] filt_level;
    wire [7:0] pin_state_view;
    wire [7:0] next_pending;
    wire [7:0] armed;
    wire [7:0] both_mode;
    wire rd_pulse;
    wire wr_pulse;
    wire [5:0] reg_addr;
    wire [7:0] wr_data;
    wire pin_state_rd;

    // ------------------------------------------------------------
    // decoding
    // ------------------------------------------------------------
    function wr_hit;
        input strobe;
        input [5:0] addr;
        input [5:0] offset;
        begin
            wr_hit = strobe && (addr == offset);
        end
    endfunction

    // ------------------------------------------------------------
    // host link
    // ------------------------------------------------------------
    gpx_spi_slave u_spi (
        .clock(clock),
        .rst(rst),
        .spi_scl(spi_scl),
        .spi_cs_n(spi_cs_n),
        .spi_si(spi_si),
        .rd_word(rd_word),
        .spi_so(spi_so),
        .spi_so_oe(spi_so_oe),
        .rd_pulse(rd_pulse),
        .wr_pulse(wr_pulse),
        .reg_addr(reg_addr),
        .wr_data(wr_data)
    );

    assign pin_state_rd = wr_hit(rd_pulse, reg_addr, `GPX_OFF_PIN_STATE);

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    // pin state and status have no write decode, so such writes
    // fall through and change nothing
    always @(posedge clock) begin
        if (rst) begin
            output_value <= `GPX_RST_OUTPUT_VALUE;
            input_polarity_invert <= `GPX_RST_POLARITY;
            pin_direction <= `GPX_RST_DIRECTION;
            pullup_enable <= `GPX_RST_PULLUP;
            input_irq_enable <= `GPX_RST_IRQ_ENABLE;
            output_highz_control <= `GPX_RST_HIGHZ;
            rising_edge_enable <= `GPX_RST_RISE_EN;
            falling_edge_enable <= `GPX_RST_FALL_EN;
            input_glitch_filter_enable <= `GPX_RST_FILTER_EN;
        end else begin
            if (wr_hit(wr_pulse, reg_addr, `GPX_OFF_OUTPUT_VALUE)) begin
                output_value <= wr_data;
            end
            if (wr_hit(wr_pulse, reg_addr, `GPX_OFF_POLARITY)) begin
                input_polarity_invert <= wr_data;
            end
            if (wr_hit(wr_pulse, reg_addr, `GPX_OFF_DIRECTION)) begin
                pin_direction <= wr_data;
            end
            if (wr_hit(wr_pulse, reg_addr, `GPX_OFF_PULLUP)) begin
                pullup_enable <= wr_data;
            end
            if (wr_hit(wr_pulse, reg_addr, `GPX_OFF_IRQ_ENABLE)) begin
                input_irq_enable <= wr_data;
            end
            if (wr_hit(wr_pulse, reg_addr, `GPX_OFF_HIGHZ)) begin
                output_highz_control <= wr_data;
            end
            if (wr_hit(wr_pulse, reg_addr, `GPX_OFF_RISE_EN)) begin
                rising_edge_enable <= wr_data;
            end
            if (wr_hit(wr_pulse, reg_addr, `GPX_OFF_FALL_EN)) begin
                falling_edge_enable <= wr_data;
            end
            if (wr_hit(wr_pulse, reg_addr, `GPX_OFF_FILTER_EN)) begin
                input_glitch_filter_enable <= wr_data;
            end
        end
    end

    // ------------------------------------------------------------
    // pin state view
    // ------------------------------------------------------------
    assign pin_state_view =
        (pin_direction & (live_level ^ input_polarity_invert)) |
        (~pin_direction & output_value);

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always @* begin
        case (reg_addr)
            `GPX_OFF_PIN_STATE: rd_next = pin_state_view;
            `GPX_OFF_OUTPUT_VALUE: rd_next = output_value;
            `GPX_OFF_POLARITY: rd_next = input_polarity_invert;
            `GPX_OFF_DIRECTION: rd_next = pin_direction;
            `GPX_OFF_PULLUP: rd_next = pullup_enable;
            `GPX_OFF_IRQ_ENABLE: rd_next = input_irq_enable;
            `GPX_OFF_HIGHZ: rd_next = output_highz_control;
            `GPX_OFF_IRQ_STATUS: rd_next = irq_pending_status;
            `GPX_OFF_RISE_EN: rd_next = rising_edge_enable;
            `GPX_OFF_FALL_EN: rd_next = falling_edge_enable;
            `GPX_OFF_FILTER_EN: rd_next = input_glitch_filter_enable;
            default: rd_next = 8'h00;
        endcase
    end

    // value captured in the same cycle that the read clears status,
    // so the host sees the state the clear acted on
    always @(posedge clock) begin
        if (rst) begin
            rd_word <= 8'h00;
        end else if (rd_pulse) begin
            rd_word <= rd_next;
        end
    end

    // ------------------------------------------------------------
    // per-pin filtering and interrupt detection
    // ------------------------------------------------------------
    assign armed = pin_direction & input_irq_enable;
    assign both_mode = ~(rising_edge_enable ^ falling_edge_enable);

    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_pin
            wire rise;
            wire fall;
            wire set_ev;
            wire clr_ev;

            gpx_pin_filter u_filt (
                .clock(clock),
                .rst(rst),
                .pin_async(gpio_pins_in[i]),
                .filt_en(input_glitch_filter_enable[i]),
                .live_level(live_level[i]),
                .filt_level(filt_level[i])
            );

            assign rise = filt_level[i] & ~prev_level[i];
            assign fall = ~filt_level[i] & prev_level[i];

            // a return edge in both-edge mode only clears
            assign set_ev = armed[i] & (both_mode[i] ?
                ((rise | fall) & (filt_level[i] != snap_level[i])) :
                ((rising_edge_enable[i] & rise) |
                 (falling_edge_enable[i] & fall)));

            assign clr_ev = pin_state_rd |
                (both_mode[i] & (filt_level[i] == snap_level[i]));

            // set wins over a clear in the same cycle
            assign next_pending[i] = set_ev |
                (irq_pending_status[i] & ~clr_ev);
        end
    endgenerate

    // ------------------------------------------------------------
    // interrupt state
    // ------------------------------------------------------------
    // the reference level follows the pin while it is not armed, so
    // enabling a pin never finds a stale reference
    always @(posedge clock) begin
        if (rst) begin
            prev_level <= 8'h00;
            snap_level <= 8'h00;
            irq_pending_status <= 8'h00;
        end else begin
            prev_level <= filt_level;
            irq_pending_status <= next_pending;
            if (pin_state_rd) begin
                snap_level <= filt_level;
            end else begin
                snap_level <= (snap_level & armed) |
                    (filt_level & ~armed);
            end
        end
    end

    // ------------------------------------------------------------
    // pin drivers and interrupt output
    // ------------------------------------------------------------
    // the drivers follow the registers one cycle later, which keeps
    // every output straight from a flip-flop
    always @(posedge clock) begin
        if (rst) begin
            gpio_pins_out <= `GPX_RST_OUTPUT_VALUE;
            gpio_pins_oe <= 8'h00;
            gpio_pullup_en <= `GPX_RST_PULLUP;
            irq_n <= 1'b1;
        end else begin
            gpio_pins_out <= output_value;
            gpio_pins_oe <= ~pin_direction &
                ~output_highz_control;
            gpio_pullup_en <= pullup_enable & pin_direction;
            irq_n <= ~(|next_pending);
        end
    end

endmodule

// [verification/gpx_port_asserts.sv]
`timescale 1ns/100ps

module gpx_port_asserts (
    input wire clock,
    input wire rst,
    input wire spi_scl,
    input wire spi_cs_n,
    input wire spi_so,
    input wire spi_so_oe,
    input wire [7:0] gpio_pins_in,
    input wire [7:0] gpio_pins_out,
    input wire [7:0] gpio_pins_oe,
    input wire [7:0] gpio_pullup_en,
    input wire irq_n
);
    // ------------------------------------------------------------
    // cycles since the pads last moved, saturating
    // ------------------------------------------------------------
    reg [7:0] pin_age;
    reg [7:0] pin_prev;

    always @(posedge clock) begin
        pin_prev <= gpio_pins_in;
        if (rst || gpio_pins_in != pin_prev)
            pin_age <= 8'h00;
        else if (pin_age != 8'hff)
            pin_age <= pin_age + 8'h01;
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_rst_outputs: assert property ($fell(rst) |-> gpio_pins_oe == 8'h00 && gpio_pins_out == 8'hff && gpio_pullup_en == 8'h00 && irq_n)
        else $error("outputs not at reset values");
    a_pull_inputs: assert property ((gpio_pullup_en & gpio_pins_oe) == 8'h00)
        else $error("pull-up on a driven pin");
    // sync, filter and status together stay well under 64 cycles
    a_irq_cause: assert property ($fell(irq_n) |-> pin_age < 8'h40)
        else $error("interrupt without a pad change");
    a_irq_clear: assert property ($rose(irq_n) |-> !spi_cs_n || pin_age < 8'h40)
        else $error("interrupt cleared without cause");
    a_so_idle_off: assert property (spi_cs_n [*8] |=> !spi_so_oe)
        else $error("data out driven while deselected");
    a_so_frame_on: assert property (!spi_cs_n [*8] |=> spi_so_oe)
        else $error("data out not driven in frame");
    a_so_hold_high: assert property (spi_scl [*6] |=> $stable(spi_so))
        else $error("data out moved while clock high");
    a_cfg_by_write: assert property ($changed({gpio_pins_out, gpio_pins_oe, gpio_pullup_en}) |-> !$past(spi_cs_n, 2))
        else $error("pin config changed outside a write");

    c_irq_set: cover property ($fell(irq_n));
    c_irq_clear: cover property ($rose(irq_n));
    c_cfg_write: cover property ($changed(gpio_pins_oe));
endmodule

bind gpx_port gpx_port_asserts gpx_port_asserts_inst (
    .clock(clock),
    .rst(rst),
    .spi_scl(spi_scl),
    .spi_cs_n(spi_cs_n),
    .spi_so(spi_so),
    .spi_so_oe(spi_so_oe),
    .gpio_pins_in(gpio_pins_in),
    .gpio_pins_out(gpio_pins_out),
    .gpio_pins_oe(gpio_pins_oe),
    .gpio_pullup_en(gpio_pullup_en),
    .irq_n(irq_n)
);

// [verification/gpx_spi_host.sv]
`timescale 1ns/100ps

module gpx_spi_host (
    input wire clock,
    input wire spi_so,
    output reg spi_scl,
    output reg spi_cs_n,
    output reg spi_si
);
    initial begin
        spi_scl = 1'b0;
        spi_cs_n = 1'b1;
        spi_si = 1'b0;
    end

    // ------------------------------------------------------------
    // one frame: command byte then data byte, 160 ns clock
    // ------------------------------------------------------------
    task automatic xfer(input logic rd, input logic [5:0] off,
                        input logic [7:0] wd, output logic [7:0] rdat);
        logic [15:0] frame;
        integer i;
        frame = {rd, off, 1'b0, wd};
        rdat = 8'h00;
        @(negedge clock);
        spi_cs_n = 1'b0;
        for (i = 15; i >= 0; i = i - 1) begin
            spi_si = frame[i];
            repeat (8) @(negedge clock);
            spi_scl = 1'b1;
            if (i < 8)
                rdat = {rdat[6:0], spi_so};
            repeat (8) @(negedge clock);
            spi_scl = 1'b0;
        end
        repeat (8) @(negedge clock);
        spi_cs_n = 1'b1;
        // released line has no pull, so it must not keep the last bit
        spi_si = ~frame[0];
        repeat (8) @(negedge clock);
    endtask
endmodule

// [verification/tb.sv]
`timescale 1ns/100ps

module tb;
    localparam integer CEILING = 60000;
    reg clock = 1'b0;
    reg rst = 1'b1;
    reg [7:0] pad = 8'h00;
    reg [7:0] rv, dir, outv, hz, pol, pu;
    reg e;
    integer failures = 0;
    integer n_compared = 0;
    integer cycles = 0;
    integer seed = 32'h1754;
    integer i, m;
    wire spi_scl, spi_cs_n, spi_si, spi_so, spi_so_oe, irq_n;
    wire [7:0] gpio_pins_out, gpio_pins_oe, gpio_pullup_en, gpio_pins_in;

    // pads follow the port where it drives, else the bench level
    assign gpio_pins_in = (gpio_pins_oe & gpio_pins_out) | (~gpio_pins_oe & pad);

    always #5 clock = ~clock;

    gpx_spi_host gpx_spi_host_inst (
        .clock(clock),
        .spi_so(spi_so),
        .spi_scl(spi_scl),
        .spi_cs_n(spi_cs_n),
        .spi_si(spi_si)
    );

    gpx_port gpx_port_inst (
        .clock(clock),
        .rst(rst),
        .spi_scl(spi_scl),
        .spi_cs_n(spi_cs_n),
        .spi_si(spi_si),
        .spi_so(spi_so),
        .spi_so_oe(spi_so_oe),
        .gpio_pins_in(gpio_pins_in),
        .gpio_pins_out(gpio_pins_out),
        .gpio_pins_oe(gpio_pins_oe),
        .gpio_pullup_en(gpio_pullup_en),
        .irq_n(irq_n)
    );

    // ------------------------------------------------------------
    // expectations and helpers
    // ------------------------------------------------------------
    function [7:0] rst_val(input integer k);
        rst_val = (k == 1 || k == 3 || k == 10) ? 8'hff : 8'h00;
    endfunction

    function [7:0] pin_exp(input [7:0] d, o, p, lvl);
        pin_exp = (d & (lvl ^ p)) | (~d & o);
    endfunction

    function exp_fire(input [1:0] mode, input up);
        exp_fire = (mode[1] == mode[0]) || (up ? mode[1] : mode[0]);
    endfunction

    task tally_and_finish;
        if (failures == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task check(input [7:0] got, input [7:0] exp, input [5:0] where);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("[FAIL] %0t at %h got %h want %h", $time, where, got, exp);
        end
    endtask

    task wr(input [5:0] off, input [7:0] d);
        reg [7:0] unused;
        gpx_spi_host_inst.xfer(1'b0, off, d, unused);
    endtask

    task rd_chk(input [5:0] off, input [7:0] exp);
        reg [7:0] got;
        gpx_spi_host_inst.xfer(1'b1, off, 8'h00, got);
        check(got, exp, off);
    endtask

    task irq_chk(input exp);
        check({7'h00, irq_n}, {7'h00, exp}, 6'h3f);
    endtask

    task wait_cyc(input integer n);
        repeat (n) @(negedge clock);
    endtask

    task do_reset;
        integer k;
        @(negedge clock);
        rst = 1'b1;
        wait_cyc(5);
        rst = 1'b0;
        for (k = 1; k <= 10; k = k + 1)
            rd_chk(k[5:0], rst_val(k));
        rd_chk(6'h0b, 8'h00);
    endtask

    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == CEILING) begin
            failures = failures + 1;
            tally_and_finish;
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        do_reset;
        for (i = 1; i <= 10; i = i + 1) begin
            rv = $random(seed);
            if (i != 7) begin
                wr(i[5:0], rv);
                rd_chk(i[5:0], rv);
            end
        end
        wr(6'h05, 8'h00);
        wr(6'h00, 8'h5a);
        wr(6'h07, 8'hff);
        rd_chk(6'h07, 8'h00);
        rd_chk(6'h0a, rv);
        for (m = 0; m < 4; m = m + 1) begin
            dir = $random(seed);
            outv = $random(seed);
            hz = $random(seed);
            pol = $random(seed);
            pu = $random(seed);
            pad = $random(seed);
            if (m == 0) begin
                dir = 8'h80;
                pol = 8'h80;
                hz = 8'h01;
            end
            wr(6'h03, dir);
            wr(6'h01, outv);
            wr(6'h06, hz);
            wr(6'h02, pol);
            wr(6'h04, pu);
            check(gpio_pins_oe, ~dir & ~hz, 6'h06);
            check(gpio_pins_out, outv, 6'h01);
            check(gpio_pullup_en, pu & dir, 6'h04);
            rd_chk(6'h00, pin_exp(dir, outv, pol, pad));
        end
        // every edge mode on pin 3, filter bypassed
        wr(6'h03, 8'hff);
        wr(6'h0a, 8'h00);
        wr(6'h02, 8'h00);
        wr(6'h05, 8'h08);
        for (m = 0; m < 4; m = m + 1) begin
            wr(6'h08, {4'h0, m[1], 3'h0});
            wr(6'h09, {4'h0, m[0], 3'h0});
            for (i = 0; i < 2; i = i + 1) begin
                rd_chk(6'h00, pad);
                pad[3] = ~pad[3];
                wait_cyc(40);
                e = exp_fire(m[1:0], pad[3]);
                irq_chk(~e);
                rd_chk(6'h07, {4'h0, e, 3'h0});
                rd_chk(6'h00, pad);
                irq_chk(1'b1);
            end
        end
        rd_chk(6'h00, pad);
        pad[3] = ~pad[3];
        wait_cyc(40);
        irq_chk(1'b0);
        pad[3] = ~pad[3];
        wait_cyc(40);
        irq_chk(1'b1);
        // rising only, filter on: 220 ns pulse dropped, 1100 ns kept
        wr(6'h09, 8'h00);
        wr(6'h0a, 8'h08);
        pad[3] = 1'b0;
        rd_chk(6'h00, pad);
        pad[3] = 1'b1;
        wait_cyc(22);
        pad[3] = 1'b0;
        wait_cyc(60);
        irq_chk(1'b1);
        pad[3] = 1'b1;
        wait_cyc(110);
        pad[3] = 1'b0;
        wait_cyc(10);
        irq_chk(1'b0);
        rd_chk(6'h07, 8'h08);
        rd_chk(6'h00, pad);
        // pin 3 as released output must stay silent
        wr(6'h0a, 8'h00);
        wr(6'h03, 8'hf7);
        wr(6'h06, 8'h08);
        wr(6'h08, 8'hff);
        pad[3] = 1'b1;
        wait_cyc(40);
        irq_chk(1'b1);
        rd_chk(6'h07, 8'h00);
        do_reset;
        tally_and_finish;
    end
endmodule
